// ==== verilog/down_counter_divider_pkg.sv ====
package down_counter_divider_pkg;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] DIVISOR_OFS = 4'h4;
    localparam logic [3:0] TBASE_OFS   = 4'h8;
    localparam logic [3:0] STATUS_OFS  = 4'hC;

    // Control register field positions
    localparam int START_BIT     = 0;
    localparam int STOP_BIT      = 1;
    localparam int TB_EN_BIT     = 2;
    localparam int EDGE_BIT      = 3;
    localparam int GATE_LSB      = 4;
    localparam int OUT_LSB       = 8;

    // Reset values
    localparam logic [31:0] DIVISOR_RST = 32'h0000_0002;
    localparam logic [31:0] TBASE_RST   = 32'h0000_0064;

    localparam logic [2:0] GATE_NONE = 3'h0;
    localparam logic [2:0] GATE_HIGH = 3'h1;
    localparam logic [2:0] GATE_LOW  = 3'h2;
    localparam logic [2:0] GATE_RISE = 3'h3;
    localparam logic [2:0] GATE_FALL = 3'h4;

    localparam logic [1:0] OUT_HPULSE = 2'h0;
    localparam logic [1:0] OUT_LPULSE = 2'h1;
    localparam logic [1:0] OUT_HTOG   = 2'h2;
    localparam logic [1:0] OUT_LTOG   = 2'h3;

    typedef struct packed {
        logic       tb_en;
        logic       src_fall;
        logic [2:0] gate_mode;
        logic [1:0] out_mode;
    } cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN   = 3'b100
    } run_state_e;

endpackage

// ==== verilog/down_counter_divider.sv ====
`timescale 1ns/1ps

// Function
// - Positive timebase counts ticks, else source pin
// - Divisor loaded, decremented per selected edge
// - Gate mode 0 ignores gate, starts immediately
// - Gate mode 1 counts while gate high
// - Gate mode 2 counts while gate low
// - Gate mode 3 starts on gate rise
// - Gate mode 4 starts on gate fall
// - Edge setting picks rising or falling source
// - Output mode 0 high pulse lasting one count tick period
// - Output mode 1 low pulse lasting one count tick period
// - Output mode 2 toggles, starting high
// - Output mode 3 toggles, starting low
// - Pulse modes divide frequency by divisor
// - Toggle modes divide by twice divisor
module down_counter_divider
    import down_counter_divider_pkg::*;
#(
    parameter int CNT_W = 32
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        count_source_pin_i,
    input  wire logic        count_gate_pin_i,
    output logic             counter_output_pin_o
);

////////////////////////////////////////////////////////////////////////////

    cfg_s             cfg_q;
    logic [CNT_W-1:0] divisor_q;
    logic [31:0]      tbase_q;
    logic [31:0]      tb_cnt_q;
    logic [CNT_W-1:0] count_q;
    run_state_e       state_q;
    logic             src_q;
    logic             gate_q;
    logic             slot_q;
    logic             tog_q;
    logic             terminal_count;
    logic             tick;
    logic             src_edge;
    logic             tb_tick;
    logic             gate_ok;
    logic             start_gate;
    logic             wr;
    logic             start_cmd;
    logic             stop_cmd;
    logic [31:0]      status;

////////////////////////////////////////////////////////////////////////////
// Wishbone slave, one registered ack per request, the cycle after the strobe

    // Taken only while ack is low, so one access writes once
    assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign start_cmd = wr && wb_adr_i == CTRL_OFS && wb_sel_i[0]
                       && wb_dat_i[START_BIT];
    assign stop_cmd  = wr && wb_adr_i == CTRL_OFS && wb_sel_i[0]
                       && wb_dat_i[STOP_BIT];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else if (ce_i)
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_q     <= '0;
            divisor_q <= DIVISOR_RST[CNT_W-1:0];
            tbase_q   <= TBASE_RST;
        end
        else if (ce_i && wr)
        begin
            if (wb_adr_i == CTRL_OFS)
            begin
                if (wb_sel_i[0])
                begin
                    cfg_q.tb_en     <= wb_dat_i[TB_EN_BIT];
                    cfg_q.src_fall  <= wb_dat_i[EDGE_BIT];
                    cfg_q.gate_mode <= wb_dat_i[GATE_LSB +: 3];
                end
                if (wb_sel_i[1])
                    cfg_q.out_mode  <= wb_dat_i[OUT_LSB +: 2];
            end
            else if (wb_adr_i == DIVISOR_OFS)
            begin
                for (int b = 0; b < 4; b++)
                    if (wb_sel_i[b] && b * 8 < CNT_W)
                        divisor_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            else if (wb_adr_i == TBASE_OFS)
            begin
                for (int b = 0; b < 4; b++)
                    if (wb_sel_i[b])
                        tbase_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end

    // Cast widens a narrow counter; it would trim one over 32 bits
    assign status = 32'(count_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o)
        begin
            case (wb_adr_i)
                CTRL_OFS:
                    wb_dat_o <= {20'h0_0000, state_q == ST_RUN,
                                 state_q == ST_ARMED, cfg_q.out_mode,
                                 1'b0, cfg_q.gate_mode, cfg_q.src_fall,
                                 cfg_q.tb_en, 2'b00};
                DIVISOR_OFS: wb_dat_o <= 32'(divisor_q);
                TBASE_OFS:   wb_dat_o <= tbase_q;
                STATUS_OFS:  wb_dat_o <= status;
                default:     wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////
// Count clock: source pin edge or internal timebase tick

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_q  <= 1'b0;
            gate_q <= 1'b0;
        end
        else if (ce_i)
        begin
            src_q  <= count_source_pin_i;
            gate_q <= count_gate_pin_i;
        end
    end

    // Timebase register holds clk cycles per tick; zero means source pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tb_cnt_q <= 32'h0000_0000;
        else if (ce_i)
        begin
            if (!cfg_q.tb_en || tb_cnt_q == 32'h0000_0000)
                tb_cnt_q <= (tbase_q == 32'h0000_0000) ? 32'h0000_0000
                                                       : tbase_q - 32'd1;
            else
                tb_cnt_q <= tb_cnt_q - 32'd1;
        end
    end

    assign tb_tick  = cfg_q.tb_en && tbase_q != 32'h0000_0000
                      && tb_cnt_q == 32'h0000_0000;
    // Pin against last sample, so the tick costs no extra cycle
    assign src_edge = cfg_q.src_fall
                      ? (src_q && !count_source_pin_i)
                      : (!src_q && count_source_pin_i);
    assign tick     = (cfg_q.tb_en && tbase_q != 32'h0000_0000)
                      ? tb_tick : src_edge;

////////////////////////////////////////////////////////////////////////////
// Gate qualification and run state

    always_comb
    begin
        case (cfg_q.gate_mode)
            GATE_HIGH: gate_ok = count_gate_pin_i;
            GATE_LOW:  gate_ok = !count_gate_pin_i;
            default:   gate_ok = 1'b1;
        endcase
    end

    always_comb
    begin
        case (cfg_q.gate_mode)
            GATE_RISE: start_gate = !gate_q && count_gate_pin_i;
            GATE_FALL: start_gate = gate_q && !count_gate_pin_i;
            default:   start_gate = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= ST_IDLE;
        else if (ce_i)
        begin
            // START while armed or running is ignored; STOP wins there, but START with STOP from idle arms
            case (state_q)
                ST_IDLE:
                    if (start_cmd)
                        state_q <= ST_ARMED;
                ST_ARMED:
                    if (stop_cmd)
                        state_q <= ST_IDLE;
                    else if (start_gate)
                        state_q <= ST_RUN;
                ST_RUN:
                    if (stop_cmd)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////
// Down counter

    assign terminal_count = state_q == ST_RUN && gate_ok && tick
                            && count_q <= {{(CNT_W-1){1'b0}}, 1'b1};

    // Divisor 0 behaves as 1, since a count of 1 or less ends a period
    // Inactive level gate simply withholds the decrement
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= '0;
        else if (ce_i)
        begin
            if (state_q != ST_RUN)
                count_q <= divisor_q;
            else if (terminal_count)
                count_q <= divisor_q;
            else if (tick && gate_ok)
                count_q <= count_q - 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Output shaping

    // Pulse lasts until the next count tick, i.e. one source cycle or timebase tick period
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            slot_q <= 1'b0;
        else if (ce_i)
        begin
            if (terminal_count)
                slot_q <= 1'b1;
            else if (tick || state_q != ST_RUN)
                slot_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tog_q <= 1'b0;
        else if (ce_i)
        begin
            if (state_q != ST_RUN)
                tog_q <= 1'b0;
            else if (terminal_count)
                tog_q <= !tog_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            counter_output_pin_o <= 1'b0;
        else if (ce_i)
        begin
            // Registered pin, so decode changes never glitch it
            case (cfg_q.out_mode)
                OUT_HPULSE: counter_output_pin_o <= terminal_count
                    || (slot_q && !tick);
                OUT_LPULSE: counter_output_pin_o <= !(terminal_count
                    || (slot_q && !tick));
                OUT_HTOG:   counter_output_pin_o <= !(tog_q
                    ^ terminal_count);
                OUT_LTOG:   counter_output_pin_o <= tog_q
                    ^ terminal_count;
                default:    counter_output_pin_o <= 1'b0;
            endcase
        end
    end

endmodule

// ==== verif/dcd_asserts.sv ====
`timescale 1ns/1ps
module dcd_asserts
    import down_counter_divider_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        count_source_pin_i,
    input wire logic        counter_output_pin_o
);
    logic tb_q;
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    // Timebase ticks are invisible here, so pin checks skip that mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tb_q <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == CTRL_OFS)
            tb_q <= wb_dat_i[TB_EN_BIT];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (req |=> wb_ack_o)
        else $error("no ack");
    ack_once_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack too long");
    ack_idle_a: assert property (!wb_cyc_i && ce_i |=> !wb_ack_o)
        else $error("stray ack");
    unmap_read_a: assert property (req && !wb_we_i && wb_adr_i[1:0] != 0
        |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read");
    dat_hold_a: assert property (!wb_cyc_i && ce_i |=> $stable(wb_dat_o))
        else $error("read data moved");
    ce_freeze_a: assert property (!ce_i |=> $stable(wb_ack_o)
        && $stable(counter_output_pin_o)) else $error("frozen state moved");
    rst_quiet_a: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !counter_output_pin_o
        && wb_dat_o == 32'h0000_0000) else $error("not idle after reset");
    out_quiet_a: assert property ((!tb_q && !wb_cyc_i && ce_i
        && $stable(count_source_pin_i))[*5]
        |-> $stable(counter_output_pin_o)) else $error("output moved");
    cover property (wb_ack_o && wb_we_i);
    cover property ($rose(counter_output_pin_o));
    cover property (!ce_i);
endmodule
bind down_counter_divider dcd_asserts dcd_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .count_source_pin_i(count_source_pin_i),
    .counter_output_pin_o(counter_output_pin_o));

// ==== verif/signal_partner.sv ====
`timescale 1ns/1ps
module signal_partner #(
    parameter int HALF = 4
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic out_pin_i,
    output logic      src_o,
    output int        rises_o,
    output int        high_o
);
    int   ph_q;
    logic out_q;
    // Source rests low between bursts, as an idle line would
    always_ff @(posedge clk_i)
    begin
        ph_q  <= run_i ? (ph_q + 1) % (2 * HALF) : 0;
        src_o <= run_i && ph_q >= HALF;
    end
    // The load counts rising edges and high cycles of the output
    always_ff @(posedge clk_i)
    begin
        out_q   <= out_pin_i;
        rises_o <= rst_i ? 0 : rises_o + int'(out_pin_i && !out_q);
        high_o  <= rst_i ? 0 : high_o + int'(out_pin_i);
    end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %s exp %0d got %0d", n, e, g); end end
module tb
    import down_counter_divider_pkg::*;
;
    logic        rst_i = 1'b1, ce_i = 1'b1, gate = 1'b0, run = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0, sel = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic        clk_i, wb_ack_o, src, out;
    int          fail_count, compares, ticks, r0, h0, rises, high;
    down_counter_divider down_counter_divider_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .count_source_pin_i(src),
        .count_gate_pin_i(gate), .counter_output_pin_o(out));
    signal_partner signal_partner_inst (
        .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .out_pin_i(out),
        .src_o(src), .rises_o(rises), .high_o(high));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // The run needs some 2150 cycles; far beyond that is a hang
    always @(posedge clk_i)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            fail_count++;
            results();
        end
    end
    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_sel_i <= sel;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Window of 96 cycles is 12 source periods, a multiple of every period
    task automatic measure(input int er, input int eh);
        repeat (48) @(posedge clk_i);
        r0 = rises;
        h0 = high;
        repeat (96) @(posedge clk_i);
        `CHK("pulses", er, rises - r0)
        `CHK("high cycles", eh, high - h0)
        `CHK("output known", 1'b0, $isunknown(out))
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, DIVISOR_OFS, 32'h0000_0000);
        `CHK("divisor", DIVISOR_RST, rd)
        bus(1'b0, TBASE_OFS, 32'h0000_0000);
        `CHK("timebase", TBASE_RST, rd)
        bus(1'b1, 4'h1, 32'hFFFF_FFFF);
        bus(1'b0, 4'h1, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
        sel = 4'h1;
        bus(1'b1, DIVISOR_OFS, 32'hFFFF_FF07);
        sel = 4'hF;
        bus(1'b0, DIVISOR_OFS, 32'h0000_0000);
        `CHK("divisor lanes", 32'h0000_0007, rd)
        ce_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        ce_i <= 1'b1;
        run <= 1'b1;
        bus(1'b1, DIVISOR_OFS, 32'h0000_0003);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, CTRL_OFS, 32'h0000_0002);
            bus(1'b1, CTRL_OFS, (m << OUT_LSB) | (m % 2 << EDGE_BIT) | 1);
            measure(m < 2 ? 4 : 2,
                m == 1 ? 64 : (m < 2 ? 32 : 48));
        end
        run <= 1'b0;
        bus(1'b1, TBASE_OFS, 32'h0000_0004);
        bus(1'b1, CTRL_OFS, 32'h0000_0002);
        bus(1'b1, CTRL_OFS, 32'h0000_0005);
        measure(8, 32);
        bus(1'b1, TBASE_OFS, 32'h0000_0000);
        bus(1'b1, CTRL_OFS, 32'h0000_0002);
        bus(1'b1, CTRL_OFS, 32'h0000_0005);
        measure(0, 0);
        run <= 1'b1;
        for (int g = 1; g < 5; g++)
        begin
            gate <= g % 2 == 0;
            bus(1'b1, CTRL_OFS, 32'h0000_0002);
            bus(1'b1, CTRL_OFS, (g << GATE_LSB) | 1);
            measure(0, 0);
            bus(1'b0, STATUS_OFS, 32'h0000_0000);
            `CHK("held count", 32'h0000_0003, rd)
            gate <= !gate;
            measure(4, 32);
        end
        results();
    end
endmodule
